// *** design/hvtrc_pkg.sv ***
// constants, register map and types of the hv channel trip and ramp control
package hvtrc_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RAMP_TICK_NS  = 1000000;
    localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
    localparam int TRIP_TICK_MS  = 100;
    localparam int MS_CW         = 18;
    localparam int SUB_CW        = 7;
    // widths
    localparam int VW = 24;
    localparam int RW = 16;
    localparam int IW = 16;
    localparam int TW = 10;
    // trip value that selects constant-current operation
    localparam logic [TW-1:0] TRIP_CC        = 10'h3e8;
    localparam logic [IW-1:0] HW_MAX_CURRENT = 16'hffff;
    // register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_VSETA  = 8'h04;
    localparam logic [7:0] A_VSETB  = 8'h08;
    localparam logic [7:0] A_ILIMA  = 8'h0c;
    localparam logic [7:0] A_ILIMB  = 8'h10;
    localparam logic [7:0] A_RUP    = 8'h14;
    localparam logic [7:0] A_RDN    = 8'h18;
    localparam logic [7:0] A_TRIP   = 8'h1c;
    localparam logic [7:0] A_CMD    = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_SETPT  = 8'h28;
    // control fields
    localparam int B_PWR     = 0;
    localparam int B_RESTORE = 1;
    localparam int B_KILL    = 2;
    localparam int B_FIXED   = 3;
    localparam int CTRL_W    = 4;
    localparam int B_CLR     = 0;
    // status fields
    localparam int S_ON      = 0;
    localparam int S_TRIP    = 1;
    localparam int S_OC      = 2;
    localparam int S_RAMP    = 3;
    localparam int S_CNT_LSB = 16;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [VW-1:0]     VSET_RST = 24'h000000;
    localparam logic [IW-1:0]     ILIM_RST = 16'h0000;
    localparam logic [RW-1:0]     RATE_RST = 16'h0032;
    typedef enum logic [1:0] {
        CH_OFF  = 2'b00,
        CH_ON   = 2'b01,
        CH_TRIP = 2'b10
    } hvtrc_state_e;
endpackage

// *** design/hvtrc_ramp.sv ***
// output set point ramp generator
`timescale 1ns/10ps
`default_nettype none
module hvtrc_ramp (
    // clock and reset
    input  wire logic                       ref_clk_i,
    input  wire logic                       nrst_i,
    // control
    input  wire logic                       tick_i,
    input  wire logic                       kill_i,
    input  wire logic [hvtrc_pkg::VW-1:0]   target_i,
    input  wire logic [hvtrc_pkg::RW-1:0]   up_rate_i,
    input  wire logic [hvtrc_pkg::RW-1:0]   down_rate_i,
    // set point
    output logic      [hvtrc_pkg::VW-1:0]   setpoint_o
);
    localparam int PAD = hvtrc_pkg::VW - hvtrc_pkg::RW;
    wire logic [hvtrc_pkg::VW-1:0] up_ext   = {{PAD{1'b0}}, up_rate_i};
    wire logic [hvtrc_pkg::VW-1:0] dn_ext   = {{PAD{1'b0}}, down_rate_i};
    wire logic [hvtrc_pkg::VW-1:0] up_gap   = target_i - setpoint_o;
    wire logic [hvtrc_pkg::VW-1:0] dn_gap   = setpoint_o - target_i;
    wire logic                     rising   = setpoint_o < target_i;
    // never overshoot: the last step lands exactly on the target
    wire logic [hvtrc_pkg::VW-1:0] up_step  = (up_gap > up_ext) ? setpoint_o + up_ext : target_i;
    wire logic [hvtrc_pkg::VW-1:0] dn_step  = (dn_gap > dn_ext) ? setpoint_o - dn_ext : target_i;
    wire logic [hvtrc_pkg::VW-1:0] moved    = rising ? up_step : dn_step;
    wire logic [hvtrc_pkg::VW-1:0] sp_next  = kill_i ? '0 : (tick_i ? moved : setpoint_o);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            setpoint_o <= '0;
        end else begin
            setpoint_o <= sp_next;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_ramp_up_step: assert property (tick_i && !kill_i && rising |=>
        (setpoint_o > $past(setpoint_o) || $past(up_rate_i) == '0)
        && (setpoint_o - $past(setpoint_o)) <= $past(up_ext)
        && setpoint_o <= $past(target_i))
        else $error("ramp up step too large or wrong way");
    a_ramp_down_step: assert property (tick_i && !kill_i && setpoint_o > target_i |=>
        ($past(setpoint_o) - setpoint_o) <= $past(dn_ext) && setpoint_o >= $past(target_i))
        else $error("ramp down step too large or wrong way");
    a_ramp_hold: assert property (!tick_i && !kill_i |=> $stable(setpoint_o))
        else $error("set point moved without a tick");
    c_ramp_arrive: cover property (setpoint_o != target_i ##1 setpoint_o == target_i);
endmodule
`default_nettype wire

// *** design/hvtrc_top.sv ***
// hv channel on/off, ramp and over-current trip control with an ahb-lite register slave
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module hvtrc_top #(
    parameter int MS_CYCLES = hvtrc_pkg::RAMP_TICK_CYC
) (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          nrst_i,
    // ahb-lite slave
    input  wire logic                          hsel_i,
    input  wire logic [31:0]                   haddr_i,
    input  wire logic [1:0]                    htrans_i,
    input  wire logic                          hwrite_i,
    input  wire logic [2:0]                    hsize_i,
    input  wire logic [31:0]                   hwdata_i,
    input  wire logic                          hready_i,
    output logic      [31:0]                   hrdata_o,
    output logic                               hreadyout_o,
    output logic                               hresp_o,
    // channel inputs
    input  wire logic                          interlock_i,
    input  wire logic                          outputs_enable_i,
    input  wire logic                          voltage_setpoint_select_i,
    input  wire logic                          current_limit_select_i,
    input  wire logic                          overcurrent_i,
    // retained state fed back after a restart
    input  wire logic                          restore_enable_i,
    input  wire logic                          saved_power_i,
    // channel outputs
    output logic      [hvtrc_pkg::VW-1:0]      setpoint_o,
    output logic      [hvtrc_pkg::IW-1:0]      current_limit_value_o,
    output logic                               channel_on_o,
    output logic                               trip_o,
    output logic                               power_state_o,
    output logic                               power_on_restore_o
);
    // registers
    logic [hvtrc_pkg::CTRL_W-1:0] ctrl_reg;
    logic [hvtrc_pkg::VW-1:0]     voltage_setpoint_a_reg;
    logic [hvtrc_pkg::VW-1:0]     voltage_setpoint_b_reg;
    logic [hvtrc_pkg::IW-1:0]     current_limit_a_reg;
    logic [hvtrc_pkg::IW-1:0]     current_limit_b_reg;
    logic [hvtrc_pkg::RW-1:0]     ramp_up_rate_reg;
    logic [hvtrc_pkg::RW-1:0]     ramp_down_rate_reg;
    logic [hvtrc_pkg::TW-1:0]     trip_val_reg;
    logic [hvtrc_pkg::TW-1:0]     trip_cnt_reg;
    logic [hvtrc_pkg::TW-1:0]     trip_cnt_next;
    logic [hvtrc_pkg::IW-1:0]     ilimit_reg;
    hvtrc_pkg::hvtrc_state_e      state_reg;
    hvtrc_pkg::hvtrc_state_e      state_next;
    logic                         kill_reg;
    logic                         restore_done_reg;
    logic [hvtrc_pkg::MS_CW-1:0]  ms_cnt_reg;
    logic [hvtrc_pkg::SUB_CW-1:0] sub_cnt_reg;
    logic                         ms_tick_reg;
    logic                         trip_tick_reg;
    logic                         dp_wr_reg;
    logic [7:0]                   dp_addr_reg;
    logic [31:0]                  hrdata_reg;

    localparam logic [hvtrc_pkg::MS_CW-1:0]  MS_LAST  = hvtrc_pkg::MS_CW'(MS_CYCLES - 1);
    localparam logic [hvtrc_pkg::SUB_CW-1:0] SUB_LAST =
        hvtrc_pkg::SUB_CW'(hvtrc_pkg::TRIP_TICK_MS - 1);

    // bus decode: zero wait states, always okay
    wire logic        addr_ph  = hsel_i && htrans_i[1] && hready_i;
    wire logic        mapped   = haddr_i[31:8] == 24'h000000;
    wire logic        wr_ctrl  = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_CTRL;
    wire logic        wr_vseta = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_VSETA;
    wire logic        wr_vsetb = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_VSETB;
    wire logic        wr_ilima = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_ILIMA;
    wire logic        wr_ilimb = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_ILIMB;
    wire logic        wr_rup   = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_RUP;
    wire logic        wr_rdn   = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_RDN;
    wire logic        wr_trip  = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_TRIP;
    wire logic        wr_cmd   = dp_wr_reg && dp_addr_reg == hvtrc_pkg::A_CMD;

    // commands
    wire logic alarm_clr   = wr_cmd && hwdata_i[hvtrc_pkg::B_CLR];
    wire logic pwr_on_cmd  = wr_ctrl && hwdata_i[hvtrc_pkg::B_PWR];
    wire logic pwr_off_cmd = wr_ctrl && !hwdata_i[hvtrc_pkg::B_PWR];
    wire logic permitted   = !interlock_i && outputs_enable_i;
    wire logic trip_mode   = trip_val_reg < hvtrc_pkg::TRIP_CC;
    wire logic is_on       = state_reg == hvtrc_pkg::CH_ON;
    wire logic expire      = is_on && overcurrent_i && trip_mode && trip_cnt_reg == '0;
    // restore is caught one cycle after reset release, never under the reset itself
    wire logic restore_go  = !restore_done_reg && restore_enable_i && saved_power_i && permitted;
    wire logic cnt_reload  = wr_trip || alarm_clr || pwr_on_cmd || !overcurrent_i;
    wire logic cnt_dec     = is_on && overcurrent_i && trip_mode && trip_tick_reg
                             && trip_cnt_reg != '0;

    // set point and limit selection
    wire logic [hvtrc_pkg::VW-1:0] voltage_setpoint_select_val = voltage_setpoint_select_i ?
                                              voltage_setpoint_b_reg : voltage_setpoint_a_reg;
    wire logic [hvtrc_pkg::VW-1:0] target   = is_on ? voltage_setpoint_select_val : '0;
    wire logic [hvtrc_pkg::IW-1:0] lim_pick = current_limit_select_i ?
                                              current_limit_b_reg : current_limit_a_reg;
    wire logic [hvtrc_pkg::IW-1:0] lim_next = ctrl_reg[hvtrc_pkg::B_FIXED] ?
                                              hvtrc_pkg::HW_MAX_CURRENT : lim_pick;

    // read mux
    wire logic [31:0] status_w = {6'h00, trip_cnt_reg, 12'h000, setpoint_o != target,
                                  overcurrent_i, state_reg[1], state_reg[0]};
    wire logic [7:0]  ra       = haddr_i[7:0];
    wire logic [31:0] rd_mux   =
        !mapped                     ? 32'h00000000 :
        ra == hvtrc_pkg::A_CTRL     ? {28'h0000000, ctrl_reg} :
        ra == hvtrc_pkg::A_VSETA    ? {8'h00, voltage_setpoint_a_reg} :
        ra == hvtrc_pkg::A_VSETB    ? {8'h00, voltage_setpoint_b_reg} :
        ra == hvtrc_pkg::A_ILIMA    ? {16'h0000, current_limit_a_reg} :
        ra == hvtrc_pkg::A_ILIMB    ? {16'h0000, current_limit_b_reg} :
        ra == hvtrc_pkg::A_RUP      ? {16'h0000, ramp_up_rate_reg} :
        ra == hvtrc_pkg::A_RDN      ? {16'h0000, ramp_down_rate_reg} :
        ra == hvtrc_pkg::A_TRIP     ? {22'h000000, trip_val_reg} :
        ra == hvtrc_pkg::A_STATUS   ? status_w :
        ra == hvtrc_pkg::A_SETPT    ? {8'h00, setpoint_o} : 32'h00000000;

    assign hrdata_o              = hrdata_reg;
    assign hreadyout_o           = 1'b1;
    assign hresp_o               = 1'b0;
    assign current_limit_value_o = ilimit_reg;
    assign channel_on_o          = state_reg[0];
    assign trip_o                = state_reg[1];
    assign power_state_o         = ctrl_reg[hvtrc_pkg::B_PWR];
    assign power_on_restore_o    = ctrl_reg[hvtrc_pkg::B_RESTORE];

    // channel state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            hvtrc_pkg::CH_OFF: begin
                if (restore_go || (pwr_on_cmd && permitted)) begin
                    state_next = hvtrc_pkg::CH_ON;
                end
            end
            hvtrc_pkg::CH_ON: begin
                if (expire) begin
                    state_next = hvtrc_pkg::CH_TRIP;
                end else if (pwr_off_cmd || !permitted) begin
                    state_next = hvtrc_pkg::CH_OFF;
                end
            end
            hvtrc_pkg::CH_TRIP: begin
                if (pwr_on_cmd && permitted) begin
                    state_next = hvtrc_pkg::CH_ON;
                end else if (alarm_clr || pwr_on_cmd) begin
                    state_next = hvtrc_pkg::CH_OFF;
                end
            end
            default: state_next = hvtrc_pkg::CH_OFF;
        endcase
    end

    // trip counter: a reload always wins over a decrement
    always_comb begin
        trip_cnt_next = trip_cnt_reg;
        if (cnt_reload) begin
            trip_cnt_next = wr_trip ? hwdata_i[hvtrc_pkg::TW-1:0] : trip_val_reg;
        end else if (cnt_dec) begin
            trip_cnt_next = trip_cnt_reg - 10'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg        <= hvtrc_pkg::CH_OFF;
            trip_cnt_reg     <= hvtrc_pkg::TRIP_CC;
            kill_reg         <= 1'b0;
            restore_done_reg <= 1'b0;
            ilimit_reg       <= hvtrc_pkg::ILIM_RST;
        end else begin
            state_reg        <= state_next;
            trip_cnt_reg     <= trip_cnt_next;
            restore_done_reg <= 1'b1;
            ilimit_reg       <= lim_next;
            if (expire) begin
                kill_reg <= ctrl_reg[hvtrc_pkg::B_KILL];
            end else if (state_next == hvtrc_pkg::CH_ON) begin
                kill_reg <= 1'b0;
            end
        end
    end

    // tick dividers: 1 ms ramp tick, 100 ms trip tick
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ms_cnt_reg    <= '0;
            sub_cnt_reg   <= '0;
            ms_tick_reg   <= 1'b0;
            trip_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg   <= ms_cnt_reg == MS_LAST;
            trip_tick_reg <= ms_cnt_reg == MS_LAST && sub_cnt_reg == SUB_LAST;
            ms_cnt_reg    <= (ms_cnt_reg == MS_LAST) ? '0 : ms_cnt_reg + 1'b1;
            if (ms_cnt_reg == MS_LAST) begin
                sub_cnt_reg <= (sub_cnt_reg == SUB_LAST) ? '0 : sub_cnt_reg + 1'b1;
            end
        end
    end

    // bus slave
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h00000000;
        end else begin
            dp_wr_reg   <= addr_ph && hwrite_i && mapped;
            dp_addr_reg <= haddr_i[7:0];
            hrdata_reg  <= (addr_ph && !hwrite_i) ? rd_mux : 32'h00000000;
        end
    end

    // software registers
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg               <= hvtrc_pkg::CTRL_RST;
            voltage_setpoint_a_reg <= hvtrc_pkg::VSET_RST;
            voltage_setpoint_b_reg <= hvtrc_pkg::VSET_RST;
            current_limit_a_reg    <= hvtrc_pkg::ILIM_RST;
            current_limit_b_reg    <= hvtrc_pkg::ILIM_RST;
            ramp_up_rate_reg       <= hvtrc_pkg::RATE_RST;
            ramp_down_rate_reg     <= hvtrc_pkg::RATE_RST;
            trip_val_reg           <= hvtrc_pkg::TRIP_CC;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata_i[hvtrc_pkg::CTRL_W-1:0];
            end else if (restore_go) begin
                ctrl_reg[hvtrc_pkg::B_PWR] <= 1'b1;
            end
            if (wr_vseta) begin
                voltage_setpoint_a_reg <= hwdata_i[hvtrc_pkg::VW-1:0];
            end
            if (wr_vsetb) begin
                voltage_setpoint_b_reg <= hwdata_i[hvtrc_pkg::VW-1:0];
            end
            if (wr_ilima) begin
                current_limit_a_reg <= hwdata_i[hvtrc_pkg::IW-1:0];
            end
            if (wr_ilimb) begin
                current_limit_b_reg <= hwdata_i[hvtrc_pkg::IW-1:0];
            end
            if (wr_rup) begin
                ramp_up_rate_reg <= hwdata_i[hvtrc_pkg::RW-1:0];
            end
            if (wr_rdn) begin
                ramp_down_rate_reg <= hwdata_i[hvtrc_pkg::RW-1:0];
            end
            if (wr_trip) begin
                trip_val_reg <= hwdata_i[hvtrc_pkg::TW-1:0];
            end
        end
    end

    // kill forces zero at once; every other drop follows ramp-down
    hvtrc_ramp u_ramp (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .tick_i      (ms_tick_reg),
        .kill_i      (kill_reg),
        .target_i    (target),
        .up_rate_i   (ramp_up_rate_reg),
        .down_rate_i (ramp_down_rate_reg),
        .setpoint_o  (setpoint_o)
    );

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_cc_no_trip: assert property (is_on && !trip_mode |=> !trip_o)
        else $error("channel tripped in constant-current mode");
    a_trip_expire: assert property (expire |=> trip_o && !channel_on_o)
        else $error("expired trip counter did not switch channel off");
    a_reload_write: assert property (wr_trip |=> trip_cnt_reg == $past(hwdata_i[9:0]))
        else $error("trip write did not reload counter");
    a_reload_calm: assert property (!overcurrent_i && !wr_trip |=>
        trip_cnt_reg == $past(trip_val_reg))
        else $error("counter not reloaded outside over-current");
    a_cnt_dec: assert property (cnt_dec && !cnt_reload |=>
        trip_cnt_reg == $past(trip_cnt_reg) - 10'h001)
        else $error("trip counter did not step down");
    a_cnt_hold: assert property (!trip_tick_reg && !cnt_reload |=> $stable(trip_cnt_reg))
        else $error("trip counter moved without tick");
    a_on_gated: assert property (!channel_on_o && !permitted |=> !channel_on_o)
        else $error("channel turned on while blocked");
    a_kill_drop: assert property ($rose(trip_o) && kill_reg |=> setpoint_o == '0)
        else $error("kill did not drop set point at once");
    a_trip_clear: assert property (trip_o && alarm_clr |=> !trip_o)
        else $error("alarm clear left trip status set");
    a_limit_sel: assert property (!ctrl_reg[hvtrc_pkg::B_FIXED] && !current_limit_select_i
        |=> current_limit_value_o == $past(current_limit_a_reg))
        else $error("limit a not selected while select low");
    c_trip: cover property (expire ##1 trip_o);
    c_clear: cover property (trip_o && alarm_clr);
    c_turn_on: cover property (pwr_on_cmd && permitted ##1 channel_on_o);
endmodule
`default_nettype wire

// *** verification/hvtrc_load_model.sv ***
// load model of the hv output stage: draws current and flags over-current
`timescale 1ns/10ps
`default_nettype none
module hvtrc_load_model (
    // channel state from the block
    input  wire logic                     channel_on_i,
    input  wire logic [hvtrc_pkg::IW-1:0] limit_i,
    // load demanded by the bench
    input  wire logic [hvtrc_pkg::IW-1:0] demand_i,
    // over-current flag back to the block
    output logic                          overcurrent_o
);
    // an unpowered channel draws nothing, so it can never sit in over-current
    assign overcurrent_o = channel_on_i && (demand_i > limit_i);
endmodule
`default_nettype wire

// *** verification/hvtrc_tb_top.sv ***
// register-level testbench of the hv channel trip and ramp control
`timescale 1ns/10ps
`default_nettype none
module hvtrc_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic        ilk = 1'b0, ena = 1'b1, voltage_setpoint_select = 1'b0, current_limit_select = 1'b0, rst_en = 1'b0, saved = 1'b0;
    logic [15:0] demand = 16'h0000;
    logic        oc, kill_ok = 1'b0;
    logic [31:0] hrdata_o;
    logic        hreadyout_o, channel_on_o, trip_o, hresp, pst, por;
    logic [23:0] setpoint_o, sp_prev = 24'h0;
    logic [15:0] limit;
    int          fail_count = 0, checked = 0;
    hvtrc_top #(.MS_CYCLES(10)) hvtrc_top_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp), .interlock_i(ilk), .outputs_enable_i(ena), .voltage_setpoint_select_i(voltage_setpoint_select),
        .current_limit_select_i(current_limit_select), .overcurrent_i(oc), .restore_enable_i(rst_en),
        .saved_power_i(saved), .setpoint_o(setpoint_o), .current_limit_value_o(limit),
        .channel_on_o(channel_on_o), .trip_o(trip_o), .power_state_o(pst), .power_on_restore_o(por));
    hvtrc_load_model hvtrc_load_model_inst (.channel_on_i(channel_on_o), .limit_i(limit),
        .demand_i(demand), .overcurrent_o(oc));
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk_i);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, exp, m);
    endtask
    task automatic wait_sp(input logic [23:0] v, input string m);
        for (int i = 0; i < 2000 && setpoint_o !== v; i++) @(posedge ref_clk_i);
        chk({8'h0, setpoint_o}, {8'h0, v}, m);
    endtask
    task automatic wait_trip();
        for (int i = 0; i < 5000 && trip_o !== 1'b1; i++) @(posedge ref_clk_i);
        chk({30'h0, trip_o, channel_on_o}, 32'h2, "trip and off");
    endtask
    // the ramp may never step by more than the reset rate of 50 mv per tick, except on kill
    always @(posedge ref_clk_i) begin
        if (nrst_i && !kill_ok && ((setpoint_o > sp_prev) ? setpoint_o - sp_prev
                                   : sp_prev - setpoint_o) > 24'h32) begin
            fail_count++;
            $display("MISMATCH t=%0t set point stepped too far", $time);
        end
        sp_prev <= setpoint_o;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd(hvtrc_pkg::A_CTRL, 32'h0, "ctrl reset");
        rd(hvtrc_pkg::A_RUP, 32'h32, "ramp up reset");
        rd(hvtrc_pkg::A_RDN, 32'h32, "ramp down reset");
        rd(hvtrc_pkg::A_TRIP, 32'h3e8, "trip reset");
        rd(8'h40, 32'h0, "unmapped read");
        chk({31'h0, hresp}, 32'h0, "okay response");
        wr(hvtrc_pkg::A_VSETA, 32'h64);
        wr(hvtrc_pkg::A_VSETB, 32'h14);
        wr(hvtrc_pkg::A_ILIMA, 32'h5);
        wr(hvtrc_pkg::A_ILIMB, 32'h7);
        rd(hvtrc_pkg::A_VSETA, 32'h64, "set point a readback");
        $display("test registers done");
        ilk <= 1'b1;
        wr(hvtrc_pkg::A_CTRL, 32'h1);
        repeat (5) @(posedge ref_clk_i);
        chk({31'h0, channel_on_o}, 32'h0, "on under interlock");
        ilk <= 1'b0;
        wr(hvtrc_pkg::A_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, channel_on_o}, 32'h1, "turn on");
        wait_sp(24'h64, "ramp up to set point a");
        chk({16'h0, limit}, 32'h5, "limit a");
        current_limit_select <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk({16'h0, limit}, 32'h7, "limit b");
        current_limit_select <= 1'b0;
        voltage_setpoint_select <= 1'b1;
        wait_sp(24'h14, "ramp down to set point b");
        voltage_setpoint_select <= 1'b0;
        wait_sp(24'h64, "back to set point a");
        $display("test on and ramps done");
        demand <= 16'h6;
        repeat (3000) @(posedge ref_clk_i);
        chk({30'h0, trip_o, channel_on_o}, 32'h1, "constant current holds");
        $display("test constant current done");
        wr(hvtrc_pkg::A_TRIP, 32'h3);
        repeat (1500) @(posedge ref_clk_i);
        demand <= 16'h0;
        repeat (5) @(posedge ref_clk_i);
        demand <= 16'h6;
        repeat (1500) @(posedge ref_clk_i);
        chk({30'h0, trip_o, channel_on_o}, 32'h1, "reload on over-current end");
        wait_trip();
        wait_sp(24'h0, "ramp option to zero");
        demand <= 16'h0;
        wr(hvtrc_pkg::A_CMD, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, trip_o}, 32'h0, "alarm clear");
        rd(hvtrc_pkg::A_CMD, 32'h0, "command reads zero");
        $display("test trip ramp done");
        kill_ok <= 1'b1;
        wr(hvtrc_pkg::A_CTRL, 32'h5);
        wait_sp(24'h64, "on with kill option");
        chk({30'h0, por, pst}, 32'h1, "power state outputs");
        rd(hvtrc_pkg::A_STATUS, 32'h00030001, "status on with count reloaded");
        rd(hvtrc_pkg::A_SETPT, 32'h64, "set point readback");
        demand <= 16'h6;
        wait_trip();
        repeat (2) @(posedge ref_clk_i);
        chk({8'h0, setpoint_o}, 32'h0, "kill drops at once");
        demand <= 16'h0;
        repeat (2) @(posedge ref_clk_i);
        kill_ok <= 1'b0;
        $display("test trip kill done");
        wr(hvtrc_pkg::A_CTRL, 32'h9);
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, trip_o}, 32'h0, "power on clears trip");
        chk({16'h0, limit}, 32'hffff, "fixed protection limit");
        wait_sp(24'h64, "on with fixed protection");
        ena <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, channel_on_o}, 32'h0, "disable forces off");
        wait_sp(24'h0, "disable ramps to zero");
        ena <= 1'b1;
        $display("test fixed and disable done");
        // restart stimulus: retained settings stand before reset is released
        rst_en <= 1'b1;
        saved <= 1'b1;
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, channel_on_o}, 32'h1, "restore enabled");
        chk({31'h0, pst}, 32'h1, "restored power bit");
        rst_en <= 1'b0;
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, channel_on_o}, 32'h0, "restore disabled");
        $display("test restore done");
        conclude();
    end
endmodule
`default_nettype wire
